// [include/mqfb_pkg.sv]
// Package of constants and carriers for the multi-queue flag boundary block
package mqfb_pkg;
  localparam int NQ = 8;
  localparam int QW = 3;
  localparam int DW = 16;
  localparam int CW = 18;
  // Width ratio modes
  localparam logic [1:0] MODE_18_18 = 2'h0;
  localparam logic [1:0] MODE_9_9 = 2'h1;
  localparam logic [1:0] MODE_18_9 = 2'h2;
  localparam logic [1:0] MODE_9_18 = 2'h3;
  // Default offsets picked by default_offset_select
  localparam logic [DW-1:0] DEF_OFFSET_LO = 16'h0008;
  localparam logic [DW-1:0] DEF_OFFSET_HI = 16'h0080;
  localparam logic [DW-1:0] DEPTH_RST = 16'h0800;
  localparam logic [1:0] MODE_RST = 2'h0;
  // Register byte offsets
  localparam logic [4:0] REG_CTRL = 5'h00;
  localparam logic [4:0] REG_DEPTH = 5'h04;
  localparam logic [4:0] REG_AE_OFS = 5'h08;
  localparam logic [4:0] REG_AF_OFS = 5'h0c;
  localparam logic [4:0] REG_FLAGS = 5'h10;
  localparam logic [4:0] REG_IRQ_ST = 5'h14;
  localparam logic [4:0] REG_IRQ_MASK = 5'h18;
  localparam logic [4:0] REG_FILL = 5'h1c;
  // Interrupt status bit positions
  localparam int IRQ_FULL = 0;
  localparam int IRQ_AFULL = 1;
  localparam int IRQ_EMPTY = 2;
  localparam int IRQ_W = 3;
  localparam logic [31:0] UNMAPPED_DATA = 32'h00000000;
  // Threshold kinds
  typedef enum logic [1:0] {
    MQFB_K_FULL = 2'b00,
    MQFB_K_AE = 2'b01,
    MQFB_K_AF = 2'b10,
    MQFB_K_OV = 2'b11
  } mqfb_kind_e;
  // Queue port carriers
  typedef struct packed {
    logic en;
    logic [QW-1:0] queue;
  } mqfb_port_s;
  typedef struct packed {
    logic output_valid_n;
    logic full_n;
    logic almost_empty_n;
    logic almost_full_n;
  } mqfb_flags_s;
endpackage : mqfb_pkg

// [src/mqfb_flags.sv]
// Flag boundary and latency logic for an eight-queue flow-control buffer
// Overview of operation
// (R01) Output valid goes low one cycle after a write to the read queue.
// (R02) Output valid goes high on the very edge of the emptying read.
// (R03) Equal widths, both ports on queue: full after depth plus one writes.
// (R04) Full after depth writes: equal write-only, and 18-in 9-out always.
// (R05) 9-in 18-out: full after 2(depth+1) writes if both, else 2*depth.
// (R06) Full asserts on the write; releases one cycle after a read.
// (R07) Almost empty high after n+2, n+1, or 2(n+2) writes by width.
// (R08) Offsets default to 8 or 128 from the select pin at reset.
// (R09) Almost empty low two cycles after read, high one after write.
// (R10) Almost empty bus bit high after n+2 or n+1 writes, doubled 9-18.
// (R11) Almost empty bus bit low two cycles after read, high one after.
// (R12) Read queue switch may add one cycle to the empty bus bits.
// (R13) Almost full low after D+1-m, D-m or 2(D+1-m) writes.
// (R14) Almost full low two cycles after write, high one after read.
// (R15) Almost full bus bit low two cycles after write, high one after.
// (R16) Write queue switch may add one cycle to the full bus bits.
// (R17) Output valid after first write; 9-in 18-out only after second.
//
// Chosen here: register access over Avalon-MM and the placing of the registers.
`timescale 1ns/100ps
module mqfb_flags
  import mqfb_pkg::*;
(
  input wire logic clock, // 250 MHz system clock
  input wire logic rst, // Async reset, active high
  input wire logic [4:0] avs_address, // Register byte address
  input wire logic avs_read, // Read strobe
  input wire logic avs_write, // Write strobe
  input wire logic [31:0] avs_writedata, // Write data
  input wire logic [3:0] avs_byteenable, // Byte lanes
  output logic [31:0] avs_readdata, // Read data
  output logic avs_waitrequest, // Stall while answer is prepared
  input wire mqfb_port_s wr_port, // Write port: enable and queue
  input wire mqfb_port_s rd_port, // Read port: enable and queue
  input wire logic default_offset_select, // Pin, sampled after reset
  output mqfb_flags_s flags, // Active queue flags, active low
  output logic [NQ-1:0] almost_empty_bus, // Per-queue, low is almost empty
  output logic [NQ-1:0] almost_full_bus, // Per-queue, low is almost full
  output logic irq // Level interrupt
);

  // Counting model
  // Every queue keeps its fill in 9-bit units, so one counter serves all
  // four width modes: an 18-bit write adds two units, a 9-bit write one,
  // and reads take two or one the same way.
  // Thresholds are held in the same units. The extra word of the
  // both-ports arrangement stands for the word that already sits in the
  // output stage. It is remembered per queue when a write opens an empty
  // queue, since the read queue may move away afterwards.
  // 18-in 9-out never earns that extra word: half of the first wide word
  // fills the output stage and the other half stays queued.
  //
  // Edge map, k being the edge that takes a write or a read
  //   full_n          low at k after a write, high at k+1 after a read
  //   output_valid_n  low at k+1 after a write, high at k after a read
  //   almost_empty_n  high at k+1 after a write, low at k+2 after a read
  //   almost_full_n   low at k+2 after a write, high at k+1 after a read
  //   bus bits        follow the same map as their selected flags
  // The k+2 edges come from a delayed copy of the almost-empty and almost-full
  // states; that flag is the OR or AND of the copy and the live state.
  // Limitation: one clock stands in for both port clocks, so the skew
  // windows are always met and no optional cycle is ever added.
  // Limitation: depth and offsets are shared by all eight queues.
  // Hazard: a depth or offset written while queues hold data moves the
  // boundaries at once; flags may jump without any write or read.

  // Example, depth 16, offsets 8, mode 18/18 with both ports:
  //   full after 17 writes, 34 units
  //   almost empty high after 10 writes, 20 units
  //   almost full low after 9 writes, 18 units
  //   output valid after 1 write, 2 units
  // Mode 9/18, same settings: 34, 20, 18 and 2 writes of one unit each

  // Write-count threshold in halfword units for one flag kind
  function automatic logic [CW-1:0] thr_units(
    input logic [1:0] mode,
    input logic both,
    input mqfb_kind_e kind,
    input logic [DW-1:0] depth,
    input logic [DW-1:0] aeo,
    input logic [DW-1:0] afo
  );
    logic [CW-1:0] base;
    logic add;
    base = '0;
    add = both && (mode != MODE_18_9) && (kind != MQFB_K_OV);
    case (kind)
      MQFB_K_FULL: base = {2'h0, depth};
      MQFB_K_AE: base = {2'h0, aeo} + 18'h00001;
      MQFB_K_AF: base = (afo > depth) ? '0 : {2'h0, depth - afo};
      default: base = 18'h00001;
    endcase
    base = base + {17'h00000, add};
    // Doubling for narrow-in wide-out; halfword scaling for wide writes
    if (mode == MODE_9_18 || mode == MODE_18_18 || mode == MODE_18_9) begin
      base = {base[CW-2:0], 1'b0};
    end
    return base;
  endfunction : thr_units

  // Halfwords per write and per read
  function automatic logic [CW-1:0] wsz(input logic [1:0] mode);
    return (mode == MODE_18_18 || mode == MODE_18_9) ? 18'h00002 : 18'h00001;
  endfunction : wsz

  function automatic logic [CW-1:0] rsz(input logic [1:0] mode);
    return (mode == MODE_18_18 || mode == MODE_9_18) ? 18'h00002 : 18'h00001;
  endfunction : rsz

  // Pin synchroniser, kept out of reset so that it tracks the pin all
  // through reset and holds a settled value when reset is let go
  logic dsel_s1_r;
  logic dsel_s2_r;
  logic init_done_r;

  always_ff @(posedge clock) begin
    dsel_s1_r <= default_offset_select;
    dsel_s2_r <= dsel_s1_r;
  end

  // Configuration registers
  logic [1:0] mode_r;
  logic [DW-1:0] depth_r;
  logic [DW-1:0] ae_ofs_r;
  logic [DW-1:0] af_ofs_r;
  logic [IRQ_W-1:0] irq_st_r;
  logic [IRQ_W-1:0] irq_mask_r;
  logic ack_r;
  logic [31:0] rdata_r;

  // Bus decode: one wait state, then the access completes
  // Every access takes two edges: the first loads the answer and raises
  // the acknowledge, the second completes it. Fixed latency keeps the
  // master simple and gives the read mux a full cycle to settle.
  wire logic req = avs_read | avs_write;
  wire logic wr_acc = avs_write & ack_r;
  wire logic we_ctrl = wr_acc && avs_address == REG_CTRL &&
    avs_byteenable[0];
  wire logic we_depth = wr_acc && avs_address == REG_DEPTH;
  wire logic we_aeo = wr_acc && avs_address == REG_AE_OFS;
  wire logic we_afo = wr_acc && avs_address == REG_AF_OFS;
  wire logic we_ist = wr_acc && avs_address == REG_IRQ_ST &&
    avs_byteenable[0];
  wire logic we_msk = wr_acc && avs_address == REG_IRQ_MASK &&
    avs_byteenable[0];
  assign avs_waitrequest = req & ~ack_r;
  assign avs_readdata = rdata_r;

  // Queue fill state in halfword units
  logic [CW-1:0] cnt_r [NQ];
  logic [CW-1:0] cnt_nxt [NQ];
  logic [NQ-1:0] both_r;
  // Delayed boundary copies and registered bus bits
  logic [NQ-1:0] ae_d1_r;
  logic [NQ-1:0] af_d1_r;
  logic [NQ-1:0] ae_bus_r;
  logic [NQ-1:0] af_bus_r;

  wire logic [CW-1:0] wq_cnt = cnt_r[wr_port.queue];
  wire logic [CW-1:0] rq_cnt = cnt_r[rd_port.queue];
  wire logic wq_full = wq_cnt >= thr_units(mode_r, both_r[wr_port.queue],
    MQFB_K_FULL, depth_r, ae_ofs_r, af_ofs_r);
  // Writes at the full boundary and reads past empty are dropped
  wire logic wr_ok = wr_port.en & ~wq_full;
  wire logic rd_ok = rd_port.en & (rq_cnt >= rsz(mode_r));

  // Next fill count per queue
  always_comb begin
    for (int q = 0; q < NQ; q++) begin
      cnt_nxt[q] = cnt_r[q];
      if (wr_ok && wr_port.queue == QW'(q)) begin
        cnt_nxt[q] = cnt_nxt[q] + wsz(mode_r);
      end
      if (rd_ok && rd_port.queue == QW'(q)) begin
        cnt_nxt[q] = cnt_nxt[q] - rsz(mode_r);
      end
    end
  end

  // Per-queue raw boundary states, current and next
  logic [NQ-1:0] ae_now;
  logic [NQ-1:0] af_now;
  logic [NQ-1:0] full_nxt;
  logic [NQ-1:0] ov_now;
  logic [NQ-1:0] ov_nxt;

  always_comb begin
    for (int q = 0; q < NQ; q++) begin
      ae_now[q] = cnt_r[q] >= thr_units(mode_r, both_r[q], MQFB_K_AE,
        depth_r, ae_ofs_r, af_ofs_r); // R07 R10
      af_now[q] = cnt_r[q] >= thr_units(mode_r, both_r[q], MQFB_K_AF,
        depth_r, ae_ofs_r, af_ofs_r); // R13
      full_nxt[q] = cnt_nxt[q] >= thr_units(mode_r, both_r[q], MQFB_K_FULL,
        depth_r, ae_ofs_r, af_ofs_r); // R03 R04 R05
      ov_now[q] = cnt_r[q] >= thr_units(mode_r, both_r[q], MQFB_K_OV,
        depth_r, ae_ofs_r, af_ofs_r); // R17
      ov_nxt[q] = cnt_nxt[q] >= thr_units(mode_r, both_r[q], MQFB_K_OV,
        depth_r, ae_ofs_r, af_ofs_r);
    end
  end

  wire logic [QW-1:0] wq = wr_port.queue;
  wire logic [QW-1:0] rq = rd_port.queue;
  // Full releases only after the stored count drops, one cycle after a read
  wire logic full_now_w = wq_cnt >= thr_units(mode_r, both_r[wq],
    MQFB_K_FULL, depth_r, ae_ofs_r, af_ofs_r);

  // Fill counters and first-word port arrangement
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      for (int q = 0; q < NQ; q++) cnt_r[q] <= '0;
      both_r <= '0;
    end else begin
      for (int q = 0; q < NQ; q++) begin
        cnt_r[q] <= cnt_nxt[q];
        if (wr_ok && wq == QW'(q) && cnt_r[q] == '0) begin
          both_r[q] <= (rq == wq);
        end
      end
    end
  end

  // Bus flags: the lagging stage stretches one edge of each flag
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      ae_d1_r <= '0;
      af_d1_r <= '0;
      ae_bus_r <= '0;
      af_bus_r <= '1;
    end else begin
      ae_d1_r <= ae_now;
      af_d1_r <= af_now;
      ae_bus_r <= ae_now | ae_d1_r; // R09 R11 R12
      af_bus_r <= ~(af_now & af_d1_r); // R14 R15 R16
    end
  end
  assign almost_empty_bus = ae_bus_r;
  assign almost_full_bus = af_bus_r;

  // Active queue flags for the selected queues
  mqfb_flags_s flags_r;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      flags_r <= '{output_valid_n: 1'b1, full_n: 1'b1,
                   almost_empty_n: 1'b0, almost_full_n: 1'b1};
    end else begin
      // Valid looks ahead so that the emptying read clears it at once
      flags_r.output_valid_n <= ~(ov_now[rq] & ov_nxt[rq]); // R01 R02
      // Full looks ahead on a write and lags one edge on a read
      flags_r.full_n <= ~(full_nxt[wq] | full_now_w); // R06
      flags_r.almost_empty_n <= ae_now[rq] | ae_d1_r[rq]; // R09
      flags_r.almost_full_n <= ~(af_now[wq] & af_d1_r[wq]); // R14
    end
  end
  assign flags = flags_r;

  // Interrupt events on the active write and read queues
  // Each event is the flag's next value against its present value, so
  // it fires in the cycle before the flag moves and only once per edge
  wire logic ev_full = flags_r.full_n & ~(full_nxt[wq] | full_now_w);
  wire logic ev_afull = flags_r.almost_full_n & ~(af_now[wq] & af_d1_r[wq]);
  wire logic ev_empty = ~flags_r.output_valid_n & ~(ov_now[rq] & ov_nxt[rq]);
  wire logic [IRQ_W-1:0] ev_vec = {ev_empty, ev_afull, ev_full};
  wire logic [IRQ_W-1:0] ist_clr = we_ist ? avs_writedata[IRQ_W-1:0] : '0;
  assign irq = |(irq_st_r & irq_mask_r);

  // Registers; a new event wins over a same-cycle clear
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      mode_r <= MODE_RST;
      depth_r <= DEPTH_RST;
      ae_ofs_r <= DEF_OFFSET_LO;
      af_ofs_r <= DEF_OFFSET_LO;
      init_done_r <= 1'b0;
      irq_st_r <= '0;
      irq_mask_r <= '0;
    end else begin
      init_done_r <= 1'b1;
      irq_st_r <= (irq_st_r & ~ist_clr) | ev_vec;
      if (!init_done_r) begin
        ae_ofs_r <= dsel_s2_r ? DEF_OFFSET_HI : DEF_OFFSET_LO; // R08
        af_ofs_r <= dsel_s2_r ? DEF_OFFSET_HI : DEF_OFFSET_LO; // R08
      end else begin
        if (we_aeo) ae_ofs_r <= avs_writedata[DW-1:0];
        if (we_afo) af_ofs_r <= avs_writedata[DW-1:0];
      end
      if (we_ctrl) mode_r <= avs_writedata[1:0];
      if (we_depth) depth_r <= avs_writedata[DW-1:0];
      if (we_msk) irq_mask_r <= avs_writedata[IRQ_W-1:0];
    end
  end

  // Register map, byte offsets
  //   0x00 mode, 0 = 18/18, 1 = 9/9, 2 = 18 in 9 out, 3 = 9 in 18 out
  //   0x04 queue depth in words, shared by all queues
  //   0x08 almost-empty offset
  //   0x0c almost-full offset
  //   0x10 flags [3:0], empty bus [19:12], full bus [27:20]
  //   0x14 event status, write one to clear
  //        bit 0 full fell, bit 1 almost full fell, bit 2 valid rose
  //   0x18 event mask, same layout
  //   0x1c fill of the read queue in 9-bit units
  // Unmapped offsets read as zero and ignore writes.

  // Read mux
  logic [31:0] rmux;

  always_comb begin
    case (avs_address)
      REG_CTRL: rmux = {30'h0, mode_r};
      REG_DEPTH: rmux = {16'h0, depth_r};
      REG_AE_OFS: rmux = {16'h0, ae_ofs_r};
      REG_AF_OFS: rmux = {16'h0, af_ofs_r};
      REG_FLAGS: rmux = {4'h0, almost_full_bus, almost_empty_bus, 8'h00,
                         flags_r};
      REG_IRQ_ST: rmux = {29'h0, irq_st_r};
      REG_IRQ_MASK: rmux = {29'h0, irq_mask_r};
      REG_FILL: rmux = {14'h0, rq_cnt};
      default: rmux = UNMAPPED_DATA;
    endcase
  end

  // Answer handshake, read data ready when waitrequest falls
  // The acknowledge toggles off after each completion, so a request held
  // on straight away starts a fresh two-edge access
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      ack_r <= 1'b0;
      rdata_r <= '0;
    end else begin
      ack_r <= req & ~ack_r;
      if (avs_read && !ack_r) rdata_r <= rmux;
    end
  end

endmodule : mqfb_flags

// [testbench/mqfb_monitor.sv]
// Checker of the flag latencies seen at the block ports
`timescale 1ns/100ps
module mqfb_monitor
  import mqfb_pkg::*;
(
  input wire logic clock, // Clock
  input wire logic rst, // Reset
  input wire mqfb_port_s wr_port, // Write port
  input wire mqfb_port_s rd_port, // Read port
  input wire mqfb_flags_s flags, // Selected flags
  input wire logic [NQ-1:0] almost_full_bus // Full bus
);
  // One domain, so one clock and one disable serve all
  default clocking dc @(posedge clock);
  endclocking
  default disable iff (rst);
  property p_ffs;
    $fell(flags.full_n) |-> $past(wr_port.en);
  endproperty
  a_ffs: assert property (p_ffs) else $error("full w/o write");
  property p_ffc;
    $rose(flags.full_n) |-> $past(rd_port.en, 2);
  endproperty
  a_ffc: assert property (p_ffc) else $error("full rel timing");
  property p_ovs;
    $fell(flags.output_valid_n) |-> $past(wr_port.en, 2);
  endproperty
  a_ovs: assert property (p_ovs) else $error("valid timing");
  property p_ovc;
    $rose(flags.output_valid_n) |-> $past(rd_port.en);
  endproperty
  a_ovc: assert property (p_ovc) else $error("empty timing");
  property p_aec;
    $fell(flags.almost_empty_n) |-> $past(rd_port.en, 3);
  endproperty
  a_aec: assert property (p_aec) else $error("ae low timing");
  property p_aes;
    $rose(flags.almost_empty_n) |-> $past(wr_port.en, 2);
  endproperty
  a_aes: assert property (p_aes) else $error("ae high timing");
  property p_afs;
    $fell(flags.almost_full_n) |-> $past(wr_port.en, 3);
  endproperty
  a_afs: assert property (p_afs) else $error("af low timing");
  property p_bfs;
    $fell(almost_full_bus[0]) |-> $past(wr_port.en, 3);
  endproperty
  a_bfs: assert property (p_bfs) else $error("af bus timing");
endmodule : mqfb_monitor

// [testbench/mqfb_host.sv]
// Host model driving the queue write and read ports
`timescale 1ns/100ps
module mqfb_host
  import mqfb_pkg::*;
(
  input wire logic clock, // Clock
  input wire logic rst, // Reset
  input wire logic wr_go, // Write wanted
  input wire logic rd_go, // Read wanted
  input wire logic [QW-1:0] rq, // Read queue
  output mqfb_port_s wr_port, // Write port
  output mqfb_port_s rd_port // Read port
);
  // Launched just after an edge; write queue fixed at zero
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      wr_port <= '0;
      rd_port <= '0;
    end else begin
      wr_port <= {wr_go, 3'h0};
      rd_port <= {rd_go, rq};
    end
  end
endmodule : mqfb_host

// [testbench/mqfb_flags_tb.sv]
// Self-checking bench for the flag boundary block
`timescale 1ns/100ps
module mqfb_flags_tb
  import mqfb_pkg::*;
;
  logic clock, rst, avs_read, avs_write, sel, wr_go, rd_go, wait_r, irq;
  logic [4:0] addr;
  logic [31:0] wdata, rdata;
  logic [QW-1:0] rq;
  logic [NQ-1:0] ae_bus, af_bus;
  mqfb_port_s wr_port, rd_port;
  mqfb_flags_s flags;
  int n_errors, checks;
  // Block under test and its host
  mqfb_flags dut (.clock(clock), .rst(rst), .avs_address(addr),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(wdata),
    .avs_byteenable(4'hf), .avs_readdata(rdata),
    .avs_waitrequest(wait_r), .wr_port(wr_port), .rd_port(rd_port),
    .default_offset_select(sel), .flags(flags),
    .almost_empty_bus(ae_bus), .almost_full_bus(af_bus), .irq(irq));
  mqfb_host host (.clock(clock), .rst(rst), .wr_go(wr_go), .rd_go(rd_go),
    .rq(rq), .wr_port(wr_port), .rd_port(rd_port));
  // 250 MHz clock
  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checks++;
    if (g !== e) begin
      n_errors++;
      $display("MISMATCH t=%0t got %h exp %h", $time, g, e);
    end
  endtask : chk
  // One access, held until waitrequest is seen low
  task automatic bus(input logic w, input logic [4:0] a,
    input logic [31:0] d, output logic [31:0] q);
    int t;
    t = 0;
    @(posedge clock);
    addr <= a;
    avs_write <= w;
    avs_read <= !w;
    wdata <= d;
    do begin
      @(posedge clock);
      t++;
    end while (wait_r !== 1'b0 && t < 50);
    q = rdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    if (t >= 50) begin
      n_errors++;
      give_verdict();
    end
  endtask : bus
  // Pin settled well before reset is let go
  task automatic do_reset(input logic s);
    sel <= s;
    wr_go <= 1'b0;
    rd_go <= 1'b0;
    rst <= 1'b1;
    repeat (20) @(posedge clock);
    rst <= 1'b0;
    repeat (2) @(posedge clock);
  endtask : do_reset
  task automatic give_verdict;
    if (n_errors == 0 && checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : give_verdict
  // Fill past full, optionally drain, following the flags each edge; valid and almost empty only when both ports use queue 0
  task automatic fill_row(input logic [1:0] md, input logic both,
    input int nf, input int nae, input int naf, input int nov,
    input logic drain);
    logic [31:0] r;
    int c0, c1, c2, mx1, mn1, mx2, mn2;
    do_reset(1'b0);
    bus(1'b1, REG_DEPTH, 32'h10, r);
    bus(1'b1, REG_CTRL, {30'h0, md}, r);
    rq <= both ? 3'h0 : 3'h1;
    c0 = 0;
    c1 = 0;
    for (int e = 0; e < 2 * nf + 12; e++) begin
      @(posedge clock);
      c2 = c1;
      c1 = c0;
      if (wr_port.en && c0 < nf) c0++;
      if (rd_port.en && c0 > 0) c0--;
      wr_go <= e < nf + 1;
      rd_go <= drain && e > nf + 3 && e < 2 * nf + 6;
      #1;
      mx1 = c0 > c1 ? c0 : c1;
      mn1 = c0 < c1 ? c0 : c1;
      mx2 = c1 > c2 ? c1 : c2;
      mn2 = c1 < c2 ? c1 : c2;
      chk(32'(flags.full_n), 32'(mx1 < nf));
      chk(32'(flags.almost_full_n), 32'(mn2 < naf));
      chk(32'(af_bus[0]), 32'(mn2 < naf));
      chk(32'(ae_bus[0]), 32'(mx2 >= nae));
      if (both) begin
        chk(32'(flags.almost_empty_n), 32'(mx2 >= nae));
        chk(32'(flags.output_valid_n), 32'(mn1 < nov));
      end
    end
  endtask : fill_row
  // Default offsets, register reads and the full interrupt
  task automatic reg_irq;
    logic [31:0] r;
    do_reset(1'b1);
    bus(1'b0, REG_AE_OFS, 32'h0, r);
    chk(r, 32'h80);
    bus(1'b0, 5'h02, 32'h0, r);
    chk(r, 32'h0);
    do_reset(1'b0);
    bus(1'b0, REG_AF_OFS, 32'h0, r);
    chk(r, 32'h8);
    bus(1'b1, REG_DEPTH, 32'h10, r);
    bus(1'b1, REG_IRQ_MASK, 32'h0, r);
    rq <= 3'h0;
    wr_go <= 1'b1;
    repeat (22) @(posedge clock);
    wr_go <= 1'b0;
    #1;
    chk(32'(irq), 32'h0);
    bus(1'b0, REG_IRQ_ST, 32'h0, r);
    chk({30'h0, r[1:0]}, 32'h3);
    bus(1'b1, REG_IRQ_MASK, 32'h1, r);
    #1;
    chk(32'(irq), 32'h1);
    bus(1'b1, REG_IRQ_ST, 32'h1, r);
    #1;
    chk(32'(irq), 32'h0);
  endtask : reg_irq
  // Main sequence: width modes, port arrangements, then registers
  initial begin
    {avs_read, avs_write, addr, wdata, rq} = '0;
    n_errors = 0;
    checks = 0;
    fill_row(2'h0, 1'b1, 17, 10, 9, 1, 1'b1);
    fill_row(2'h1, 1'b1, 17, 10, 9, 1, 1'b0);
    fill_row(2'h2, 1'b1, 16, 9, 8, 1, 1'b0);
    fill_row(2'h3, 1'b1, 34, 20, 18, 2, 1'b0);
    fill_row(2'h0, 1'b0, 16, 9, 8, 1, 1'b0);
    fill_row(2'h3, 1'b0, 32, 18, 16, 1, 1'b0);
    reg_irq();
    give_verdict();
  end
  // Hang guard
  initial begin
    #200000;
    n_errors++;
    give_verdict();
  end
endmodule : mqfb_flags_tb
bind mqfb_flags mqfb_monitor mon (.clock(clock), .rst(rst),
  .wr_port(wr_port), .rd_port(rd_port), .flags(flags),
  .almost_full_bus(almost_full_bus));
